/* logic/fcu_convert_unit.v */
`timescale 1ns/1ps
`include "fcu_defines.vh"

module fcu_convert_unit (
   input  wire        clk,
   input  wire        sys_rst,
   input  wire        ce,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire        irq
);

   localparam ST_IDLE = 1'b0;
   localparam ST_EXEC = 1'b1;

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   reg                 aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
   reg  [7:0]          awaddr_q;
   reg  [31:0]         wdata_q, rdata_q;
   reg  [3:0]          wstrb_q;
   reg  [1:0]          bresp_q, rresp_q;
   reg  [31:0]         ctrl_q, cmd_q, a_lo_q, a_hi_q, b_q, res_lo_q, res_hi_q;
   reg  [`FCU_EV_W-1:0] ev_q, mask_q;
   reg  [4:0]          cause_q;
   reg                 written_q, state_q;

   wire [63:0]         src_a = {a_hi_q, a_lo_q};
   wire [2:0]          op    = cmd_q[`FCU_CMD_OP];
   wire [1:0]          fmt   = cmd_q[`FCU_CMD_FMT];
   wire [1:0]          rm    = ctrl_q[`FCU_CTRL_RM];

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  st;
      integer      k;
      begin
         for (k = 0; k < 4; k = k + 1)
            merge[8*k +: 8] = st[k] ? nw[8*k +: 8] : old[8*k +: 8];
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `FCU_OFF_CTRL) | (a == `FCU_OFF_CMD) | (a == `FCU_OFF_SRC_A_LO) |
                  (a == `FCU_OFF_SRC_A_HI) | (a == `FCU_OFF_SRC_B) |
                  (a == `FCU_OFF_RES_LO) | (a == `FCU_OFF_RES_HI) |
                  (a == `FCU_OFF_EVT) | (a == `FCU_OFF_MASK) | (a == `FCU_OFF_STATUS);
      end
   endfunction

   function [6:0] lzc;
      input [63:0] v;
      integer      i;
      reg          found;
      begin
         lzc   = 7'h40;
         found = 1'b0;
         for (i = 63; i >= 0; i = i - 1)
            if (!found && v[i]) begin
               lzc   = 7'h3f - i[6:0];
               found = 1'b1;
            end
      end
   endfunction

   // ----------------------------------------------------------------------------
   // Source unpacking into sign, exponent and normalised 64-bit mantissa
   // ----------------------------------------------------------------------------
   reg                 sgn, nan, snan, inf, den;
   reg  [12:0]         e_raw;
   reg  [63:0]         m_raw;

   always @* begin
      sgn   = 1'b0;
      nan   = 1'b0;
      snan  = 1'b0;
      inf   = 1'b0;
      den   = 1'b0;
      e_raw = 13'h0000;
      m_raw = 64'h0;
      case (fmt)
         `FCU_FMT_S: begin
            sgn   = src_a[31];
            nan   = (&src_a[30:23]) & (|src_a[22:0]);
            inf   = (&src_a[30:23]) & ~(|src_a[22:0]);
            den   = ~(|src_a[30:23]) & (|src_a[22:0]);
            snan  = nan & ~src_a[22];
            m_raw = {|src_a[30:23], src_a[22:0], 40'h0};
            e_raw = ((|src_a[30:23]) ? {5'h00, src_a[30:23]} : 13'h0001) - `FCU_BIAS_S;
         end
         `FCU_FMT_D: begin
            sgn   = src_a[63];
            nan   = (&src_a[62:52]) & (|src_a[51:0]);
            inf   = (&src_a[62:52]) & ~(|src_a[51:0]);
            den   = ~(|src_a[62:52]) & (|src_a[51:0]);
            snan  = nan & ~src_a[51];
            m_raw = {|src_a[62:52], src_a[51:0], 11'h000};
            e_raw = ((|src_a[62:52]) ? {2'h0, src_a[62:52]} : 13'h0001) - `FCU_BIAS_D;
         end
         `FCU_FMT_W: begin
            sgn   = src_a[31];
            m_raw = {(src_a[31] ? (~src_a[31:0] + 32'h1) : src_a[31:0]), 32'h0};
            e_raw = `FCU_E_WORD;
         end
         default: begin
            sgn   = src_a[63];
            m_raw = src_a[63] ? (~src_a + 64'h1) : src_a;
            e_raw = `FCU_E_LONG;
         end
      endcase
   end

   wire                zero = ~(|m_raw);
   wire [6:0]          lz   = lzc(m_raw);
   wire [63:0]         m_n  = m_raw << lz;
   wire [12:0]         e_n  = e_raw - {6'h00, lz};

   // ----------------------------------------------------------------------------
   // Alignment and rounding, one shifter and one rounder for every target
   // ----------------------------------------------------------------------------
   wire [12:0]         diff_s = `FCU_EMIN_S - e_n;
   wire [12:0]         diff_l = `FCU_E_LONG - e_n;
   wire                den_s  = $signed(e_n) < $signed(`FCU_EMIN_S);
   wire                big_s  = $signed(e_n) > $signed(`FCU_EMAX_S);
   wire                big_l  = $signed(e_n) > $signed(`FCU_E_LONG);
   wire [6:0]          clamp_s = (diff_s > {6'h00, `FCU_SHR_MAX}) ? `FCU_SHR_MAX : diff_s[6:0];
   wire [6:0]          clamp_l = (diff_l > {6'h00, `FCU_SHR_MAX}) ? `FCU_SHR_MAX : diff_l[6:0];
   reg  [6:0]          amt;
   reg                 r_lsb, r_g, r_st;
   wire [65:0]         t;
   wire                sh_st, inc, r_inx;

   always @* begin
      amt   = 7'h00;
      r_lsb = t[13];
      r_g   = t[12];
      r_st  = (|t[11:0]) | sh_st;
      if (op == `FCU_OP_CVT_S) begin
         amt   = den_s ? clamp_s : 7'h00;
         r_lsb = t[42];
         r_g   = t[41];
         r_st  = (|t[40:0]) | sh_st;
      end else if (op == `FCU_OP_CVT_L) begin
         amt   = big_l ? 7'h00 : clamp_l;
         r_lsb = t[2];
         r_g   = t[1];
         r_st  = t[0] | sh_st;
      end
   end

   fcu_shift_sticky u_shift (
      .din    ({m_n, 2'h0}),
      .amt    (amt),
      .dout   (t),
      .sticky (sh_st)
   );

   // The same rounder and the same mode field serve every rounding conversion.
   fcu_round_decide u_round (
      .rm      (rm),
      .sign    (sgn),
      .lsb     (r_lsb),
      .guard   (r_g),
      .sticky  (r_st),
      .inc     (inc),
      .inexact (r_inx)
   );

   // Exponent rides above the mantissa so a rounding carry bumps it for free.
   wire [10:0]         e_d  = e_n[10:0] + `FCU_EB_D_M1;
   wire [62:0]         magd = {e_d, 52'h0} + {10'h000, t[65:13]} + {62'h0, inc};
   wire [7:0]          e_s  = den_s ? 8'h00 : e_n[7:0] + `FCU_EB_S_M1;
   wire [31:0]         mags = {1'b0, e_s, 23'h0} + {8'h00, t[65:42]} + {31'h0, inc};
   wire                ovf_s = big_s | (&mags[30:23]);
   wire                to_max = (rm == `FCU_RM_ZERO) | ((rm == `FCU_RM_UP) & sgn) |
                                ((rm == `FCU_RM_DOWN) & ~sgn);
   wire [64:0]         ri   = {1'b0, t[65:2]} + {64'h0, inc};
   wire                lim_l = ri[64] | (ri[63] & (~sgn | (|ri[62:0])));

   // ----------------------------------------------------------------------------
   // Result and flag selection
   // ----------------------------------------------------------------------------
   reg  [63:0]         res;
   reg  [4:0]          flg;
   reg                 rsv, arith, needs_wide;

   always @* begin
      res        = 64'h0;
      flg        = 5'h00;
      rsv        = 1'b0;
      arith      = 1'b1;
      needs_wide = (fmt == `FCU_FMT_L);
      case (op)
         `FCU_OP_CVT_D: begin
            rsv = (fmt == `FCU_FMT_D);
            if (nan) begin
               res          = `FCU_QNAN_D;
               flg[`FCU_F_INV] = snan;
            end else if (inf)
               res = {sgn, `FCU_INF_D};
            else if (zero)
               res = {sgn, 63'h0};
            else begin
               res = {sgn, magd};
               flg[`FCU_F_INX] = r_inx & (fmt == `FCU_FMT_L);
            end
         end
         `FCU_OP_CVT_S: begin
            rsv = (fmt == `FCU_FMT_S);
            if (nan) begin
               res          = {32'h0, `FCU_QNAN_S};
               flg[`FCU_F_INV] = snan;
            end else if (inf)
               res = {32'h0, sgn, `FCU_INF_S};
            else if (zero)
               res = {32'h0, sgn, 31'h0};
            else if (ovf_s) begin
               res = {32'h0, sgn, (to_max ? `FCU_MAXF_S : `FCU_INF_S)};
               flg[`FCU_F_OVF] = 1'b1;
               flg[`FCU_F_INX] = 1'b1;
            end else begin
               res = {32'h0, sgn, mags[30:0]};
               flg[`FCU_F_INX] = r_inx;
               flg[`FCU_F_UNF] = den_s & r_inx;
            end
         end
         `FCU_OP_CVT_L: begin
            rsv        = (fmt == `FCU_FMT_W) | (fmt == `FCU_FMT_L);
            needs_wide = 1'b1;
            if (nan | inf | big_l | lim_l) begin
               res          = `FCU_DEF_L;
               flg[`FCU_F_INV] = 1'b1;
            end else begin
               res          = sgn ? (~ri[63:0] + 64'h1) : ri[63:0];
               flg[`FCU_F_INX] = r_inx;
            end
         end
         `FCU_OP_PACK: begin
            arith      = 1'b0;
            needs_wide = 1'b1;
            res        = {a_lo_q, b_q};
         end
         `FCU_OP_EXT_LO: begin
            arith      = 1'b0;
            needs_wide = 1'b1;
            res        = {32'h0, src_a[31:0]};
         end
         `FCU_OP_EXT_HI: begin
            arith      = 1'b0;
            needs_wide = 1'b1;
            res        = {32'h0, src_a[63:32]};
         end
         default: rsv = 1'b1;
      endcase
      // Trap mode for hosts that emulate denormals in software.
      if (arith & ctrl_q[`FCU_CTRL_DTRAP] &
          (den | ((op == `FCU_OP_CVT_S) & den_s & ~zero & ~nan & ~inf)))
         flg[`FCU_F_UNI] = 1'b1;
      // Outside the wide mode these results are undefined; zero is returned.
      if (needs_wide & ~ctrl_q[`FCU_CTRL_WIDE])
         res = 64'h0;
   end

   wire                cpu  = ~ctrl_q[`FCU_CTRL_COPEN];
   wire                take = flg[`FCU_F_UNI] | (|(flg & ctrl_q[`FCU_CTRL_EN]));

   // ----------------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------------
   assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
   assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;
   assign irq           = |(ev_q & mask_q);

   wire                wr_fire = aw_hold_q & w_hold_q & ~bvalid_q;
   wire [31:0]         wmask   = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
                                  {8{wstrb_q[0]}}};
   wire                cmd_go  = wr_fire & (awaddr_q == `FCU_OFF_CMD) & (state_q == ST_IDLE);
   wire [`FCU_EV_W-1:0] ev_clr = (wr_fire & (awaddr_q == `FCU_OFF_EVT)) ?
                                 (wdata_q[`FCU_EV_W-1:0] & wmask[`FCU_EV_W-1:0]) : 9'h000;
   reg  [`FCU_EV_W-1:0] ev_set;
   reg  [31:0]         rd_word;
   wire [31:0]         mask_nx = merge({23'h0, mask_q}, wdata_q, wstrb_q);

   always @* begin
      case (s_axi_araddr)
         `FCU_OFF_CTRL:     rd_word = ctrl_q;
         `FCU_OFF_CMD:      rd_word = cmd_q;
         `FCU_OFF_SRC_A_LO: rd_word = a_lo_q;
         `FCU_OFF_SRC_A_HI: rd_word = a_hi_q;
         `FCU_OFF_SRC_B:    rd_word = b_q;
         `FCU_OFF_RES_LO:   rd_word = res_lo_q;
         `FCU_OFF_RES_HI:   rd_word = res_hi_q;
         `FCU_OFF_EVT:      rd_word = {23'h0, ev_q};
         `FCU_OFF_MASK:     rd_word = {23'h0, mask_q};
         `FCU_OFF_STATUS:   rd_word = {22'h0, written_q, state_q, 3'h0, cause_q};
         default:           rd_word = 32'h0;
      endcase
   end

   always @* begin
      ev_set = 9'h000;
      if (state_q == ST_EXEC) begin
         ev_set[`FCU_EV_DONE] = 1'b1;
         if (cpu) begin
            ev_set[`FCU_EV_CPU] = 1'b1;
            ev_set[`FCU_EV_EXC] = 1'b1;
         end else if (rsv) begin
            ev_set[`FCU_EV_RSV] = 1'b1;
            ev_set[`FCU_EV_EXC] = 1'b1;
         end else begin
            ev_set[4:0]         = flg;
            ev_set[`FCU_EV_EXC] = take;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------------
   always @(posedge clk) begin
      if (sys_rst) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         rvalid_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
         bresp_q   <= `FCU_RESP_OKAY;
         rresp_q   <= `FCU_RESP_OKAY;
         rdata_q   <= 32'h0;
         ctrl_q    <= `FCU_CTRL_RST;
         cmd_q     <= 32'h0;
         a_lo_q    <= 32'h0;
         a_hi_q    <= 32'h0;
         b_q       <= 32'h0;
         res_lo_q  <= 32'h0;
         res_hi_q  <= 32'h0;
         ev_q      <= 9'h000;
         mask_q    <= 9'h000;
         cause_q   <= 5'h00;
         written_q <= 1'b0;
         state_q   <= ST_IDLE;
      end else if (ce) begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_hold_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= mapped(awaddr_q) ? `FCU_RESP_OKAY : `FCU_RESP_DECERR;
            case (awaddr_q)
               `FCU_OFF_CTRL:
                  ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & `FCU_CTRL_WMASK;
               `FCU_OFF_SRC_A_LO: a_lo_q <= merge(a_lo_q, wdata_q, wstrb_q);
               `FCU_OFF_SRC_A_HI: a_hi_q <= merge(a_hi_q, wdata_q, wstrb_q);
               `FCU_OFF_SRC_B:    b_q    <= merge(b_q, wdata_q, wstrb_q);
               `FCU_OFF_MASK:
                  mask_q <= mask_nx[`FCU_EV_W-1:0];
               default: ;
            endcase
         end else if (bvalid_q & s_axi_bready)
            bvalid_q <= 1'b0;
         if (s_axi_arvalid & ~rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= mapped(s_axi_araddr) ? `FCU_RESP_OKAY : `FCU_RESP_DECERR;
         end else if (rvalid_q & s_axi_rready)
            rvalid_q <= 1'b0;
         // A new event wins over a clear written in the same cycle.
         ev_q <= (ev_q & ~ev_clr) | ev_set;
         case (state_q)
            ST_IDLE: begin
               if (cmd_go) begin
                  cmd_q   <= merge(cmd_q, wdata_q, wstrb_q);
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               state_q   <= ST_IDLE;
               cause_q   <= (cpu | rsv) ? 5'h00 : flg;
               written_q <= ~cpu & ~rsv & ~take;
               if (~cpu & ~rsv & ~take) begin
                  res_lo_q <= res[31:0];
                  res_hi_q <= res[63:32];
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

endmodule

/* logic/fcu_defines.vh */
`ifndef FCU_DEFINES_VH
`define FCU_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define FCU_OFF_CTRL     8'h00
`define FCU_OFF_CMD      8'h04
`define FCU_OFF_SRC_A_LO 8'h08
`define FCU_OFF_SRC_A_HI 8'h0c
`define FCU_OFF_SRC_B    8'h10
`define FCU_OFF_RES_LO   8'h14
`define FCU_OFF_RES_HI   8'h18
`define FCU_OFF_EVT      8'h1c
`define FCU_OFF_MASK     8'h20
`define FCU_OFF_STATUS   8'h24

// ----------------------------------------------------------------------------
// Control register (fp_control_status_reg) fields and reset value
// ----------------------------------------------------------------------------
`define FCU_CTRL_RM      1:0
`define FCU_CTRL_EN      6:2
`define FCU_CTRL_WIDE    8
`define FCU_CTRL_COPEN   9
`define FCU_CTRL_DTRAP   10
`define FCU_CTRL_WMASK   32'h0000077f
`define FCU_CTRL_RST     32'h00000300

// ----------------------------------------------------------------------------
// Command register fields, operations and source formats
// ----------------------------------------------------------------------------
`define FCU_CMD_OP       2:0
`define FCU_CMD_FMT      5:4
`define FCU_OP_CVT_D     3'h0
`define FCU_OP_CVT_S     3'h1
`define FCU_OP_CVT_L     3'h2
`define FCU_OP_PACK      3'h3
`define FCU_OP_EXT_LO    3'h4
`define FCU_OP_EXT_HI    3'h5
`define FCU_FMT_S        2'h0
`define FCU_FMT_D        2'h1
`define FCU_FMT_W        2'h2
`define FCU_FMT_L        2'h3

// ----------------------------------------------------------------------------
// Rounding modes
// ----------------------------------------------------------------------------
`define FCU_RM_NEAR      2'h0
`define FCU_RM_ZERO      2'h1
`define FCU_RM_UP        2'h2
`define FCU_RM_DOWN      2'h3

// ----------------------------------------------------------------------------
// Flag bits (also low bits of event, mask and enable fields) and events
// ----------------------------------------------------------------------------
`define FCU_F_INX        0
`define FCU_F_UNF        1
`define FCU_F_OVF        2
`define FCU_F_INV        3
`define FCU_F_UNI        4
`define FCU_EV_DONE      5
`define FCU_EV_EXC       6
`define FCU_EV_CPU       7
`define FCU_EV_RSV       8
`define FCU_EV_W         9
`define FCU_ST_CAUSE     4:0
`define FCU_ST_BUSY      8
`define FCU_ST_WRITTEN   9

// ----------------------------------------------------------------------------
// Number formats
// ----------------------------------------------------------------------------
`define FCU_BIAS_S       13'h007f
`define FCU_BIAS_D       13'h03ff
`define FCU_EMIN_S       13'h1f82
`define FCU_EMAX_S       13'h007f
`define FCU_E_WORD       13'h001f
`define FCU_E_LONG       13'h003f
`define FCU_EB_S_M1      8'h7e
`define FCU_EB_D_M1      11'h3fe
`define FCU_SHR_MAX      7'h42
`define FCU_QNAN_S       32'h7fc00000
`define FCU_QNAN_D       64'h7ff8000000000000
`define FCU_INF_S        31'h7f800000
`define FCU_INF_D        63'h7ff0000000000000
`define FCU_MAXF_S       31'h7f7fffff
`define FCU_DEF_L        64'h7fffffffffffffff

// ----------------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------------
`define FCU_RESP_OKAY    2'h0
`define FCU_RESP_DECERR  2'h3

`endif

/* logic/fcu_shift_sticky.v */
`timescale 1ns/1ps
`include "fcu_defines.vh"

// ----------------------------------------------------------------------------
// Right shift that keeps every bit shifted out as one sticky bit
// ----------------------------------------------------------------------------
module fcu_shift_sticky (
   input  wire [65:0] din,
   input  wire [6:0]  amt,
   output wire [65:0] dout,
   output wire        sticky
);

   wire [65:0] keep_mask;

   assign keep_mask = {66{1'b1}} << amt;
   assign dout      = din >> amt;
   assign sticky    = |(din & ~keep_mask);

endmodule

/* logic/fcu_round_decide.v */
`timescale 1ns/1ps
`include "fcu_defines.vh"

// ----------------------------------------------------------------------------
// Round-increment decision for all four directions
// ----------------------------------------------------------------------------
module fcu_round_decide (
   input  wire [1:0] rm,
   input  wire       sign,
   input  wire       lsb,
   input  wire       guard,
   input  wire       sticky,
   output reg        inc,
   output wire       inexact
);

   assign inexact = guard | sticky;

   always @* begin
      case (rm)
         `FCU_RM_NEAR: inc = guard & (sticky | lsb);
         `FCU_RM_UP:   inc = ~sign & inexact;
         `FCU_RM_DOWN: inc = sign & inexact;
         default:      inc = 1'b0;
      endcase
   end

endmodule

/* testbench/fcu_convert_unit_sva.sv */
`timescale 1ns/1ps
module fcu_convert_unit_sva (
   input wire        clk,
   input wire        sys_rst,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer moved");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   AST_IRQSTB: assert property (!s_axi_bvalid && !$past(s_axi_bvalid) |-> $stable(irq))
      else $error("interrupt moved without a write");
   AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_WLAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
   AST_WBLK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answering");
   AST_BDROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer repeated");
   AST_IRQ: assert property ($rose(irq) |-> s_axi_bvalid || $past(s_axi_bvalid) ||
      $past(s_axi_awvalid)) else $error("interrupt without cause");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property ($rose(irq));
endmodule
bind fcu_convert_unit fcu_convert_unit_sva chk (.clk, .sys_rst, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .irq);

/* testbench/fcu_issue_model.sv */
`timescale 1ns/1ps
module fcu_issue_model (
   input  wire        clk,
   output reg  [7:0]  s_axi_awaddr,
   output reg         s_axi_awvalid,
   input  wire        s_axi_awready,
   output reg  [31:0] s_axi_wdata,
   output wire [3:0]  s_axi_wstrb,
   output reg         s_axi_wvalid,
   input  wire        s_axi_wready,
   input  wire [1:0]  s_axi_bresp,
   input  wire        s_axi_bvalid,
   output reg         s_axi_bready,
   output reg  [7:0]  s_axi_araddr,
   output reg         s_axi_arvalid,
   input  wire        s_axi_arready,
   input  wire [31:0] s_axi_rdata,
   input  wire [1:0]  s_axi_rresp,
   input  wire        s_axi_rvalid,
   output reg         s_axi_rready
);
   reg ta, tw, tb;
   reg [1:0] br;
   assign s_axi_wstrb = 4'hf;
   initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
      s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
   // Operands arrive in the declared format; wr also reaches unmapped offsets such as 8'h40.
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         {s_axi_awaddr, s_axi_wdata} <= {a, d};
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
         do begin
            @(negedge clk);
            {ta, tw, tb, br} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
               s_axi_bvalid, s_axi_bresp};
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            // Released data is scrambled so a late sample never looks correct.
            if (tw) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
         end while (!tb);
         s_axi_bready <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, output [31:0] d, output [1:0] r);
      begin
         @(posedge clk);
         {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
         do begin
            @(negedge clk);
            {ta, tb, d, r} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
         end while (!tb);
         s_axi_rready <= 1'b0;
      end
   endtask
endmodule

/* testbench/fcu_convert_unit_test.sv */
`timescale 1ns/1ps
module fcu_convert_unit_test;
   reg         clk = 1'b0;
   reg         sys_rst = 1'b1;
   wire [7:0]  s_axi_awaddr, s_axi_araddr;
   wire [31:0] s_axi_wdata, s_axi_rdata;
   wire [3:0]  s_axi_wstrb;
   wire [1:0]  s_axi_rresp, s_axi_bresp;
   wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   wire        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   integer     error_cnt = 0, comparisons = 0, cyc = 0, i;
   reg [31:0]  d;
   reg [1:0]   r;
   fcu_convert_unit dut (.clk, .sys_rst, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq);
   fcu_issue_model m (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .s_axi_bresp);
   initial forever #5 clk = ~clk;
   task test_done;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
         if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt = error_cnt + 1;
         test_done;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task rdc(input [7:0] a, input [31:0] exp);
      begin
         m.rd(a, d, r);
         chk(d, exp);
      end
   endtask
   // One conversion: control, both operands, then the command that starts it.
   task cv(input [31:0] ctl, input [63:0] a, input [31:0] b, input [31:0] cmd);
      begin
         m.wr(8'h00, ctl);
         m.wr(8'h08, a[31:0]);
         m.wr(8'h0c, a[63:32]);
         m.wr(8'h10, b);
         m.wr(8'h04, cmd);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      cv(32'h300, 64'h40000000_40400000, 32'h3f800000, 32'h3);
      rdc(8'h18, 32'h40400000);
      rdc(8'h14, 32'h3f800000);
      rdc(8'h24, 32'h200);
      cv(32'h300, 64'h40000000_40400000, 32'h0, 32'h4);
      rdc(8'h14, 32'h40400000);
      rdc(8'h24, 32'h200);
      cv(32'h300, 64'h40000000_40400000, 32'h0, 32'h5);
      rdc(8'h14, 32'h40000000);
      cv(32'h200, 64'h40000000_40400000, 32'h3f800000, 32'h3);
      rdc(8'h14, 32'h0);
      $display("paired moves done");
      cv(32'h300, 64'h0_3f800000, 32'h0, 32'h0);
      rdc(8'h18, 32'h3ff00000);
      rdc(8'h24, 32'h200);
      for (i = 0; i < 4; i = i + 1) begin
         cv(32'h300 | i, 64'h40040000_00000000, 32'h0, 32'h12);
         rdc(8'h14, (i == 2) ? 32'h3 : 32'h2);
         rdc(8'h24, 32'h201);
      end
      cv(32'h300, 64'h7ff00000_00000000, 32'h0, 32'h12);
      rdc(8'h14, 32'hffffffff);
      rdc(8'h18, 32'h7fffffff);
      rdc(8'h24, 32'h208);
      cv(32'h300, 64'h7e37e43c_8800759c, 32'h0, 32'h11);
      rdc(8'h14, 32'h7f800000);
      rdc(8'h24, 32'h205);
      $display("rounding conversions done");
      m.wr(8'h20, 32'h40);
      cv(32'h320, 64'h7ff00000_00000000, 32'h0, 32'h12);
      rdc(8'h14, 32'h7f800000);
      rdc(8'h24, 32'h8);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      m.wr(8'h1c, 32'h1ff);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      rdc(8'h40, 32'h0);
      chk({30'h0, r}, 32'h3);
      m.wr(8'h40, 32'h0);
      chk({30'h0, m.br}, 32'h3);
      cv(32'h100, 64'h0, 32'h0, 32'h10);
      cv(32'h300, 64'h0, 32'h0, 32'h10);
      rdc(8'h1c, 32'h1e0);
      $display("exceptions done");
      test_done;
   end
endmodule
